// >>> design/rcs_top.sv
`timescale 1ns/1ps
module rcs_top
  import rcs_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic [3:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [3:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic READ_GATE_IN_I,
  input wire logic QUAL_PULSE_I,
  input wire logic CODE_CLK_I,
  input wire logic CODE_BIT_I,
  input wire logic DEFECT_I,
  input wire logic EQUALIZER_COEFF_HOLD_I,
  input wire logic FULL_POWER_DOWN_N_I,
  input wire logic SERVO_GATE_I,
  input wire logic SERIAL_PORT_ENABLE_I,
  input wire logic [7:0] DEC_BYTE_I,
  input wire logic DEC_VALID_I,
  output logic INT_READ_GATE_O,
  output logic LOOP_REF_DATA_O,
  output logic DD_PD_SEL_O,
  output logic LOCK_O,
  output logic [1:0] PD_GAIN_O,
  output logic AGC_SAMPLED_O,
  output logic BOUNDARY_EN_O,
  output logic BYTE_CLK_SRC_DS_O,
  output logic BYTE_CLK_O,
  output logic [8:0] CODE_WORD_O,
  output logic CODE_WORD_VALID_O,
  output logic COEFF_HOLD_O,
  output logic LOOP_GAIN_DIV7_O,
  output logic SYNC_BYTE_FOUND_N_O,
  output logic [7:0] NRZ_O,
  output logic NRZ_OE_O,
  output logic FRONT_END_ON_O,
  output logic DATA_SYNC_ON_O,
  output logic TIMEBASE_ON_O
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [S_N-1:0] s1_ff; // First stage, read only by s2_ff
  logic [S_N-1:0] s2_ff; // Safe copies of the pins
  logic ck_d_ff; // Previous code clock level
  logic sen_d_ff; // Previous port enable level
  wire logic [S_N-1:0] pins = {SERIAL_PORT_ENABLE_I, SERVO_GATE_I,
    FULL_POWER_DOWN_N_I, EQUALIZER_COEFF_HOLD_I, DEFECT_I, CODE_BIT_I,
    CODE_CLK_I, QUAL_PULSE_I, READ_GATE_IN_I};

  // Two flops per pin; code clock and data share one sample point
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s1_ff <= '0;
      s2_ff <= '0;
      ck_d_ff <= 1'b0;
      sen_d_ff <= 1'b0;
    end else begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
      ck_d_ff <= s2_ff[S_CK];
      sen_d_ff <= s2_ff[S_SEN];
    end
  end

  logic qp_d_ff; // Previous qualified pulse level
  wire logic rg = s2_ff[S_RG];
  wire logic crise = s2_ff[S_CK] & ~ck_d_ff; // Code clock edge
  wire logic qrise = s2_ff[S_QP] & ~qp_d_ff;
  wire logic sen_fall = sen_d_ff & ~s2_ff[S_SEN];

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] ctrl_ff; // Control fields
  logic [2:0] pd_sh_ff; // Power bits as written
  logic [2:0] pd_live_ff; // Power bits in force
  rcs_state_e st_ff; // Read sequencing state
  logic [6:0] cnt_ff; // Qualified pulse count
  logic sbd_n_ff; // Sync byte found, active low
  wire logic scan = ctrl_ff[C_DSE] & ctrl_ff[C_SURVIVOR_SEQ_BYPASS] & ctrl_ff[C_BYTE];
  logic [8:0] sr_ff; // Incoming code bits
  wire logic [8:0] nxt_sr = {sr_ff[7:0], s2_ff[S_BIT]};
  // Boundary word seen on the stream once the search is enabled
  wire logic bnd_hit = BOUNDARY_EN_O && nxt_sr == TRAIN_CW;

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic aw_ok_ff; // Address held until data arrives
  logic w_ok_ff;
  logic [3:0] awa_ff;
  logic [31:0] wd_ff;
  logic [3:0] ws_ff;
  wire logic aw_hs = S_AXI_AWVALID_I & S_AXI_AWREADY_O;
  wire logic w_hs = S_AXI_WVALID_I & S_AXI_WREADY_O;
  wire logic do_wr = aw_ok_ff & w_ok_ff & ~S_AXI_BVALID_O;

  // Address and data are taken in either order
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      awa_ff <= '0;
      wd_ff <= '0;
      ws_ff <= '0;
      S_AXI_AWREADY_O <= 1'b0;
      S_AXI_WREADY_O <= 1'b0;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= RESP_OK;
    end else begin
      S_AXI_AWREADY_O <= ~aw_ok_ff & ~aw_hs;
      S_AXI_WREADY_O <= ~w_ok_ff & ~w_hs;
      if (aw_hs) begin
        aw_ok_ff <= 1'b1;
        awa_ff <= S_AXI_AWADDR_I;
      end
      if (w_hs) begin
        w_ok_ff <= 1'b1;
        wd_ff <= S_AXI_WDATA_I;
        ws_ff <= S_AXI_WSTRB_I;
      end
      if (do_wr) begin
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O <= (awa_ff == ADDR_CTRL || awa_ff == ADDR_PWR) ?
          RESP_OK : RESP_ERR;
        aw_ok_ff <= 1'b0;
        w_ok_ff <= 1'b0;
      end else if (S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
      end
    end
  end

  // Register writes; only byte lane 0 carries fields
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl_ff <= CTRL_RST[7:0];
      pd_sh_ff <= PWR_RST;
    end else if (do_wr && ws_ff[0]) begin
      // The port is never gated by power state
      if (awa_ff == ADDR_CTRL) ctrl_ff <= wd_ff[7:0];
      if (awa_ff == ADDR_PWR) pd_sh_ff <= wd_ff[2:0];
    end
  end

  // Reads answer one cycle after the address is taken
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= '0;
      S_AXI_RRESP_O <= RESP_OK;
    end else begin
      S_AXI_ARREADY_O <= ~S_AXI_RVALID_O & ~S_AXI_ARREADY_O;
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
        S_AXI_RVALID_O <= 1'b1;
        S_AXI_RRESP_O <= RESP_OK;
        case (S_AXI_ARADDR_I)
          ADDR_CTRL: S_AXI_RDATA_O <= {24'h0, ctrl_ff};
          ADDR_PWR: S_AXI_RDATA_O <= {29'h0, pd_sh_ff};
          ADDR_STAT: S_AXI_RDATA_O <= {18'h0, pd_live_ff, sbd_n_ff,
            st_ff, cnt_ff};
          default: begin
            S_AXI_RDATA_O <= '0;
            S_AXI_RRESP_O <= RESP_ERR;
          end
        endcase
      end else if (S_AXI_RREADY_I) begin
        S_AXI_RVALID_O <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Preamble counting and lock
  // ---------------------------------------------------------------
  // Gate drop returns everything to the timebase at once
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_ff <= ST_IDLE;
      cnt_ff <= '0;
      qp_d_ff <= 1'b0;
      INT_READ_GATE_O <= 1'b0;
      LOOP_REF_DATA_O <= 1'b0;
      DD_PD_SEL_O <= 1'b0;
      LOCK_O <= 1'b0;
      PD_GAIN_O <= GAIN_NONE;
      AGC_SAMPLED_O <= 1'b0;
      BOUNDARY_EN_O <= 1'b0;
      BYTE_CLK_SRC_DS_O <= 1'b0;
    end else begin
      qp_d_ff <= s2_ff[S_QP];
      if (!rg) begin
        st_ff <= ST_IDLE;
        cnt_ff <= '0;
        INT_READ_GATE_O <= 1'b0;
        LOOP_REF_DATA_O <= 1'b0;
        DD_PD_SEL_O <= 1'b0;
        LOCK_O <= 1'b0;
        PD_GAIN_O <= GAIN_NONE;
        AGC_SAMPLED_O <= 1'b0;
        BOUNDARY_EN_O <= 1'b0;
        BYTE_CLK_SRC_DS_O <= 1'b0;
      end else begin
        case (st_ff)
          ST_IDLE: st_ff <= ST_PRE;
          ST_PRE, ST_ACQ: begin
            if (qrise) cnt_ff <= cnt_ff + 7'h01;
            if (st_ff == ST_PRE && cnt_ff == ACQ_COUNT) begin
              st_ff <= ST_ACQ;
              INT_READ_GATE_O <= 1'b1;
              LOOP_REF_DATA_O <= 1'b1;
              DD_PD_SEL_O <= 1'b1;
            end
            // Count is in pulses, the field length twice that
            if (st_ff == ST_ACQ && cnt_ff == sfc_half(ctrl_ff[1:0])) begin
              st_ff <= ST_LOCK;
              LOCK_O <= 1'b1;
              if (ctrl_ff[C_GS])
                PD_GAIN_O <= ctrl_ff[C_GS10] ? GAIN_DIV10 : GAIN_DIV6;
              AGC_SAMPLED_O <= 1'b1;
              BOUNDARY_EN_O <= 1'b1;
              BYTE_CLK_SRC_DS_O <= 1'b1;
            end
          end
          ST_LOCK: if (crise && bnd_hit) st_ff <= ST_DATA;
          ST_DATA: st_ff <= ST_DATA;
          default: st_ff <= ST_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Code word alignment and byte clock
  // ---------------------------------------------------------------
  logic [3:0] bit_ff; // Bit position within a word
  logic [3:0] ph_ff; // Byte clock phase
  logic [3:0] tb_ff; // Timebase divider
  wire logic tb_tick = tb_ff == TB_DIV - 4'h1;
  wire logic tick = BYTE_CLK_SRC_DS_O ? crise : tb_tick;
  wire logic fall = tick && ph_ff == WORD_LAST; // Byte clock falls

  // Words leave only once the boundary is known
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sr_ff <= '0;
      bit_ff <= '0;
      CODE_WORD_O <= '0;
      CODE_WORD_VALID_O <= 1'b0;
    end else begin
      CODE_WORD_VALID_O <= 1'b0;
      if (crise) sr_ff <= nxt_sr;
      if (st_ff != ST_DATA || !rg) begin
        bit_ff <= '0;
      end else if (crise) begin
        bit_ff <= (bit_ff == WORD_LAST) ? 4'h0 : bit_ff + 4'h1;
        if (bit_ff == WORD_LAST) begin
          CODE_WORD_O <= nxt_sr;
          CODE_WORD_VALID_O <= 1'b1;
        end
      end
    end
  end

  // Phase is kept across the source switch, so the period around it
  // can stretch or shorten; the boundary restarts it low.
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tb_ff <= '0;
      ph_ff <= '0;
      BYTE_CLK_O <= 1'b0;
    end else begin
      tb_ff <= tb_tick ? 4'h0 : tb_ff + 4'h1;
      if (st_ff == ST_LOCK && crise && bnd_hit) begin
        ph_ff <= '0;
        BYTE_CLK_O <= 1'b0;
      end else if (tick) begin
        ph_ff <= (ph_ff == WORD_LAST) ? 4'h0 : ph_ff + 4'h1;
        BYTE_CLK_O <= ph_ff >= CLK_HI - 4'h1 && ph_ff != WORD_LAST;
      end
    end
  end

  // ---------------------------------------------------------------
  // Sync byte detection and output bytes
  // ---------------------------------------------------------------
  logic wait_ff; // First sync byte seen, delay running
  logic [4:0] dly_ff; // Code clocks since the first sync byte

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sbd_n_ff <= 1'b1;
      wait_ff <= 1'b0;
      dly_ff <= '0;
      NRZ_O <= '0;
      NRZ_OE_O <= 1'b0;
    end else begin
      NRZ_OE_O <= rg;
      if (!rg) begin
        sbd_n_ff <= 1'b1;
        wait_ff <= 1'b0;
        dly_ff <= '0;
        NRZ_O <= '0;
      end else if (scan) begin
        // Defect scan reports at lock, MSB only
        if (st_ff == ST_ACQ && cnt_ff == sfc_half(ctrl_ff[1:0]))
          sbd_n_ff <= 1'b0;
        if (!sbd_n_ff && fall) NRZ_O <= {s2_ff[S_DEF], 7'h0};
      end else if (!sbd_n_ff) begin
        if (DEC_VALID_I) NRZ_O <= DEC_BYTE_I;
      end else if (wait_ff) begin
        // The decoder keeps running; its two bytes are skipped
        if (crise) dly_ff <= dly_ff + 5'h01;
        if (crise && dly_ff == SYNC1_DLY) begin
          sbd_n_ff <= 1'b0;
          NRZ_O <= SYNC2;
        end
      end else if (st_ff == ST_DATA && DEC_VALID_I) begin
        if (DEC_BYTE_I == SYNC2) begin
          sbd_n_ff <= 1'b0;
          NRZ_O <= SYNC2;
        end else if (DEC_BYTE_I == SYNC1) begin
          wait_ff <= 1'b1;
        end
      end else begin
        NRZ_O <= '0;
      end
    end
  end
  assign SYNC_BYTE_FOUND_N_O = sbd_n_ff;

  // ---------------------------------------------------------------
  // Equalizer adaptation control
  // ---------------------------------------------------------------
  // With C_ADAPT clear, adaptation runs until sync detection, which in dual format
  // covers the training, first sync and propagation bytes
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      COEFF_HOLD_O <= 1'b0;
      LOOP_GAIN_DIV7_O <= 1'b0;
    end else begin
      COEFF_HOLD_O <= s2_ff[S_EQH] |
        (~ctrl_ff[C_ADAPT] & ~sbd_n_ff);
      LOOP_GAIN_DIV7_O <= ctrl_ff[C_ADAPT] & ~sbd_n_ff;
    end
  end

  // ---------------------------------------------------------------
  // Power management
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pd_live_ff <= PWR_RST;
      FRONT_END_ON_O <= 1'b0;
      DATA_SYNC_ON_O <= 1'b0;
      TIMEBASE_ON_O <= 1'b0;
    end else begin
      if (sen_fall) pd_live_ff <= pd_sh_ff;
      // Pin low wins over bits and servo gate
      FRONT_END_ON_O <= s2_ff[S_PDN] &
        (s2_ff[S_SG] | ~pd_live_ff[P_FE]);
      DATA_SYNC_ON_O <= s2_ff[S_PDN] & ~pd_live_ff[P_DS];
      TIMEBASE_ON_O <= s2_ff[S_PDN] & ~pd_live_ff[P_TB];
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  wire logic at_sfc = st_ff == ST_ACQ && cnt_ff == sfc_half(ctrl_ff[1:0]);

  property p_acq;
    rg && st_ff == ST_PRE && cnt_ff == ACQ_COUNT |=>
      INT_READ_GATE_O && LOOP_REF_DATA_O && DD_PD_SEL_O;
  endproperty
  a_acq: assert property (p_acq) else $error("no loop switch");
  property p_lock;
    rg && at_sfc |=> LOCK_O && AGC_SAMPLED_O && BYTE_CLK_SRC_DS_O;
  endproperty
  a_lock: assert property (p_lock) else $error("no lock");
  property p_gain;
    $rose(LOCK_O) |-> PD_GAIN_O == (!ctrl_ff[C_GS] ? GAIN_NONE :
      ctrl_ff[C_GS10] ? GAIN_DIV10 : GAIN_DIV6);
  endproperty
  a_gain: assert property (p_gain) else $error("bad gain");
  property p_resync;
    $rose(st_ff == ST_DATA) |-> ph_ff == 4'h0 && !BYTE_CLK_O;
  endproperty
  a_resync: assert property (p_resync) else $error("no resync");
  property p_word;
    CODE_WORD_VALID_O |-> st_ff == ST_DATA;
  endproperty
  a_word: assert property (p_word) else $error("early word");
  property p_hold;
    s2_ff[S_EQH] |=> COEFF_HOLD_O;
  endproperty
  a_hold: assert property (p_hold) else $error("hold lost");
  property p_sync1;
    rg && !scan && wait_ff && sbd_n_ff && crise && dly_ff == SYNC1_DLY
      |=> !sbd_n_ff && NRZ_O == SYNC2;
  endproperty
  a_sync1: assert property (p_sync1) else $error("1f late");
  property p_rgoff;
    !rg |=> sbd_n_ff && NRZ_O == 8'h00 && !NRZ_OE_O;
  endproperty
  a_rgoff: assert property (p_rgoff) else $error("not released");
  property p_pdn;
    !s2_ff[S_PDN] |=> !FRONT_END_ON_O && !DATA_SYNC_ON_O && !TIMEBASE_ON_O;
  endproperty
  a_pdn: assert property (p_pdn) else $error("not powered down");
  property p_sen;
    sen_fall |=> pd_live_ff == $past(pd_sh_ff);
  endproperty
  a_sen: assert property (p_sen) else $error("power bits late");
  c_lock: cover property (rg ##1 $rose(LOCK_O));
  c_sync: cover property ($fell(sbd_n_ff) && !scan);
  c_scan: cover property (scan && $fell(sbd_n_ff));
endmodule

// >>> design/rcs_pkg.sv
package rcs_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0; // Sequencing control
  localparam logic [3:0] ADDR_PWR = 4'h4; // Power-down shadow
  localparam logic [3:0] ADDR_STAT = 4'h8; // Read status
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [2:0] PWR_RST = 3'h0; // All sections powered
  // CTRL fields
  localparam int C_SFC = 0; // [1:0] 64/80/96/128
  localparam int C_GS = 2; // Gain switching enable
  localparam int C_GS10 = 3; // Divide by ten select
  localparam int C_ADAPT = 4; // 1: adapt into user data
  localparam int C_BYTE = 5; // Byte-wide interface
  localparam int C_SURVIVOR_SEQ_BYPASS = 6; // Survivor register bypass
  localparam int C_DSE = 7; // Defect scan enable
  // PWR fields (one turns the section off)
  localparam int P_FE = 0;
  localparam int P_DS = 1;
  localparam int P_TB = 2;
  // ---------------------------------------------------------------
  // Sequencing constants
  // ---------------------------------------------------------------
  localparam logic [6:0] ACQ_COUNT = 7'h04; // Loop switch count
  localparam logic [8:0] TRAIN_CW = 9'h133; // Encoded training word
  localparam logic [7:0] SYNC1 = 8'h1f;
  localparam logic [7:0] SYNC2 = 8'h69;
  localparam logic [4:0] SYNC1_DLY = 5'h11; // 18 code clocks, 0..17
  localparam logic [3:0] WORD_LAST = 4'h8; // Nine code bits a word
  localparam logic [3:0] CLK_HI = 4'h5; // First high byte clock phase; high for four of nine
  localparam int CLK_NS = 5;
  localparam int TB_NS = 32; // Timebase code period
  localparam logic [3:0] TB_DIV = 4'((TB_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [1:0] GAIN_NONE = 2'h0;
  localparam logic [1:0] GAIN_DIV6 = 2'h1;
  localparam logic [1:0] GAIN_DIV10 = 2'h2;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // Pin synchroniser lanes
  localparam int S_RG = 0, S_QP = 1, S_CK = 2, S_BIT = 3, S_DEF = 4;
  localparam int S_EQH = 5, S_PDN = 6, S_SG = 7, S_SEN = 8, S_N = 9;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PRE = 3'b001,
    ST_ACQ = 3'b010,
    ST_LOCK = 3'b011,
    ST_DATA = 3'b100
  } rcs_state_e;

  // Half of the selected sync field count, in qualified pulses
  function automatic logic [6:0] sfc_half(input logic [1:0] sel);
    case (sel)
      2'h0: sfc_half = 7'h20;
      2'h1: sfc_half = 7'h28;
      2'h2: sfc_half = 7'h30;
      default: sfc_half = 7'h40;
    endcase
  endfunction
endpackage

// >>> sim/rcs_ctrl_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Disk controller side of the read link
// ---------------------------------------------------------------
module rcs_ctrl_model
  import rcs_pkg::*;
(
  input wire logic clk_i,
  output logic read_gate_o,
  output logic qual_pulse_o,
  output logic code_clk_o,
  output logic code_bit_o
);
  int idx; // Bit position inside the training word
  // Quiet link at time zero
  initial begin
    read_gate_o = 1'b0;
    qual_pulse_o = 1'b0;
    code_clk_o = 1'b0;
    code_bit_o = 1'b0;
    idx = 0;
  end
  // Code clock toggles only inside a frame, stands still otherwise
  always begin
    #32;
    code_clk_o = read_gate_o ? ~code_clk_o : 1'b0;
  end
  // Training word MSB first, moved on the non-sampling edge
  always @(negedge code_clk_o) begin
    code_bit_o = TRAIN_CW[8-idx];
    idx = (idx == 8) ? 0 : idx + 1;
  end
  // Released bit line changes every cycle so no stale level survives
  always @(posedge clk_i) begin
    if (!read_gate_o) begin
      code_bit_o <= ~code_bit_o;
    end
  end
  // Raise read gate just after a clock edge
  task automatic open_frame();
    @(posedge clk_i);
    read_gate_o <= 1'b1;
  endtask
  // Drop read gate; no write ever follows from this model
  task automatic close_frame();
    @(posedge clk_i);
    read_gate_o <= 1'b0;
  endtask
  // Qualified pulses, wide enough to survive the pin synchroniser
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk_i);
      qual_pulse_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      qual_pulse_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
  endtask
endmodule

// >>> sim/read_channel_sync_and_power_ctrl_bench.sv
`timescale 1ns/1ps
module read_channel_sync_and_power_ctrl_bench;
  import rcs_pkg::*;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic sys_clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, gain, r;
  logic rg, qp, cclk, cbit, eqh, pdn_n, sg, sen, dvalid, dfx;
  logic [7:0] dbyte, nrz;
  logic irg, lref, ddsel, lock, agc, bnd, bsrc, bclk, cwv, chold, div7;
  logic sync_n, oe, fe, ds, tb;
  logic [8:0] cw;
  int err_total, cmp_count;
  rcs_ctrl_model rcs_ctrl_model_i (.clk_i(sys_clk), .read_gate_o(rg),
    .qual_pulse_o(qp), .code_clk_o(cclk), .code_bit_o(cbit));
  rcs_top rcs_top_i (.SYS_CLK_I(sys_clk), .RST_N_I(rst_n),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready), .READ_GATE_IN_I(rg), .QUAL_PULSE_I(qp),
    .CODE_CLK_I(cclk), .CODE_BIT_I(cbit), .DEFECT_I(dfx),
    .EQUALIZER_COEFF_HOLD_I(eqh), .FULL_POWER_DOWN_N_I(pdn_n),
    .SERVO_GATE_I(sg), .SERIAL_PORT_ENABLE_I(sen), .DEC_BYTE_I(dbyte),
    .DEC_VALID_I(dvalid), .INT_READ_GATE_O(irg), .LOOP_REF_DATA_O(lref),
    .DD_PD_SEL_O(ddsel), .LOCK_O(lock), .PD_GAIN_O(gain),
    .AGC_SAMPLED_O(agc), .BOUNDARY_EN_O(bnd), .BYTE_CLK_SRC_DS_O(bsrc),
    .BYTE_CLK_O(bclk), .CODE_WORD_O(cw), .CODE_WORD_VALID_O(cwv),
    .COEFF_HOLD_O(chold), .LOOP_GAIN_DIV7_O(div7),
    .SYNC_BYTE_FOUND_N_O(sync_n), .NRZ_O(nrz), .NRZ_OE_O(oe),
    .FRONT_END_ON_O(fe), .DATA_SYNC_ON_O(ds), .TIMEBASE_ON_O(tb));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Write: both channels offered together, each dropped once taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge sys_clk);
      if (awready === 1'b1 && !ad) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !wd) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    @(posedge sys_clk);
    while (bvalid !== 1'b1) @(posedge sys_clk);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    @(posedge sys_clk);
    while (arready !== 1'b1) @(posedge sys_clk);
    arvalid <= 1'b0;
    rready <= 1'b1;
    @(posedge sys_clk);
    while (rvalid !== 1'b1) @(posedge sys_clk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Opens a frame and feeds pulses up to lock; half is the count / 2
  task automatic lock_up(input int half);
    int k;
    rcs_ctrl_model_i.open_frame();
    rcs_ctrl_model_i.pulses(4);
    chk(irg, 1);
    chk(lref, 1);
    chk(ddsel, 1);
    rcs_ctrl_model_i.pulses(half - 5);
    chk(lock, 0);
    rcs_ctrl_model_i.pulses(1);
    chk(lock, 1);
    while (cwv !== 1'b1) @(posedge sys_clk);
    chk(cw, TRAIN_CW);
    k = 0;
    while (bclk !== 1'b1 && k < 100) begin
      @(posedge sys_clk);
      k++;
    end
    chk(bclk, 1);
  endtask
  task automatic send_byte(input logic [7:0] b);
    dbyte <= b;
    dvalid <= 1'b1;
    @(posedge sys_clk);
    dvalid <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    axi_rd(ADDR_CTRL);
    chk(d, CTRL_RST);
    axi_wr(ADDR_CTRL, 32'h0000_000c); // Count 64, gain cut by ten
    chk(r, RESP_OK);
    axi_rd(ADDR_CTRL);
    chk(d, 32'h0000_000c);
    axi_wr(ADDR_STAT, 32'h0000_00ff); // Read-only place refuses
    chk(r, RESP_ERR);
    axi_rd(4'hc); // Unmapped word
    chk(r, RESP_ERR);
    $display("test regs done");
  endtask
  task automatic t_pwr();
    chk({fe, ds, tb}, 3'h7);
    axi_wr(ADDR_PWR, 32'h0000_0007);
    repeat (6) @(posedge sys_clk);
    chk(fe, 1);
    sen <= 1'b1;
    repeat (4) @(posedge sys_clk);
    sen <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk({fe, ds, tb}, 3'h0);
    sg <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk({fe, ds, tb}, 3'h4);
    pdn_n <= 1'b0;
    eqh <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk({fe, ds, tb}, 3'h0);
    chk(chold, 1);
    axi_rd(ADDR_CTRL);
    chk(d, 32'h0000_000c);
    pdn_n <= 1'b1;
    sg <= 1'b0;
    eqh <= 1'b0;
    axi_wr(ADDR_PWR, 32'h0000_0000);
    sen <= 1'b1;
    repeat (4) @(posedge sys_clk);
    sen <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk({fe, ds, tb}, 3'h7);
    chk(chold, 0);
    $display("test power done");
  endtask
  task automatic t_read();
    axi_wr(ADDR_CTRL, 32'h0000_001c); // Adapt into user data
    lock_up(32);
    chk(gain, GAIN_DIV10);
    chk(div7, 0);
    chk(agc, 1);
    chk({bnd, bsrc}, 2'h3);
    chk(nrz, 0);
    chk(sync_n, 1);
    send_byte(SYNC2);
    chk(sync_n, 0);
    chk(nrz, SYNC2);
    chk(oe, 1);
    chk(div7, 1);
    chk(chold, 0);
    send_byte(8'ha5);
    chk(nrz, 8'ha5);
    rcs_ctrl_model_i.close_frame();
    repeat (6) @(posedge sys_clk);
    chk({sync_n, oe}, 2'h2);
    chk({lock, irg, bsrc, lref}, 4'h0);
    axi_rd(ADDR_STAT);
    chk(d[9:0], 10'h000);
    $display("test read done");
  endtask
  // First sync byte: found late, after eighteen code clocks
  task automatic t_sync1();
    int k;
    logic p;
    axi_wr(ADDR_CTRL, 32'h0000_0001); // Count 80, train-only adaption
    lock_up(40);
    chk(gain, GAIN_NONE);
    send_byte(SYNC1);
    k = 0;
    p = cclk;
    while (k < 20) begin
      @(posedge sys_clk);
      if (cclk && !p) begin
        k++;
        if (k == 16) chk(sync_n, 1);
        if (k == 16) chk(chold, 0);
      end
      p = cclk;
    end
    chk(sync_n, 0);
    chk(nrz, SYNC2);
    chk(chold, 1);
    rcs_ctrl_model_i.close_frame();
    repeat (6) @(posedge sys_clk);
    $display("test first sync done");
  endtask
  // Defect scan: found flag at lock, MSB follows the defect pin
  task automatic t_scan();
    axi_wr(ADDR_CTRL, 32'h0000_00e0);
    lock_up(32);
    chk(sync_n, 0);
    dfx <= 1'b1;
    repeat (250) @(posedge sys_clk);
    chk(nrz, 8'h80);
    dfx <= 1'b0;
    repeat (250) @(posedge sys_clk);
    chk(nrz, 8'h00);
    rcs_ctrl_model_i.close_frame();
    repeat (6) @(posedge sys_clk);
    $display("test scan done");
  endtask
  // ---------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {eqh, sg, sen, dvalid, dfx} = '0;
    pdn_n = 1'b1;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    dbyte = '0;
    err_total = 0;
    cmp_count = 0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_regs();
    t_pwr();
    t_read();
    t_sync1();
    t_scan();
    end_sim();
  end
  // Whole run needs well under this; a hang counts as a mismatch
  initial begin
    #400us;
    err_total++;
    end_sim();
  end
endmodule
